/* File: crtcv_pkg.sv */
// Constants shared by the vertical timing and scan address block
package crtcv_pkg;
	// ==========================================================
	// I/O ports of the indexed register file
	localparam logic [15:0] IDX_PORT   = 16'h03D4; // Index port
	localparam logic [15:0] DATA_PORT  = 16'h03D5; // Data port
	localparam logic [15:0] STAT0_PORT = 16'h03C2; // Input status zero

	// ==========================================================
	// Register indices
	localparam logic [7:0] IX_OVF     = 8'h07; // vertical_overflow
	localparam logic [7:0] IX_CELL    = 8'h09; // cell_height_control
	localparam logic [7:0] IX_VSS     = 8'h10; // Vertical sync start low
	localparam logic [7:0] IX_VSE     = 8'h11; // vsync_end_and_irq_control
	localparam logic [7:0] IX_VDE     = 8'h12; // vertical_display_end_low
	localparam logic [7:0] IX_PITCH   = 8'h13; // row_pitch
	localparam logic [7:0] IX_ULINE   = 8'h14; // underline_row_and_addr_mode
	localparam logic [7:0] IX_VBS     = 8'h15; // vertical_blank_start_low
	localparam logic [7:0] IX_VBE     = 8'h16; // vertical_blank_end_low
	localparam logic [7:0] IX_MODE    = 8'h17; // timing_mode_control
	localparam logic [7:0] IX_LCMP    = 8'h18; // split_line_compare_low
	localparam logic [7:0] IX_EXTA    = 8'h1A; // misc_extension_a
	localparam logic [7:0] IX_EXTB    = 8'h1B; // display_extension_b
	localparam logic [7:0] IX_WP_LAST = 8'h07; // Last protected index
	localparam logic [7:0] REG_RST    = 8'h00; // Reset value of registers
	localparam logic [7:0] OVF_LC_MASK = 8'h10; // Always-writable bit

	// ==========================================================
	// Field positions
	localparam int B_WP      = 7; // Write protect
	localparam int B_REF5    = 6; // Five refresh cycles
	localparam int B_IDIS    = 5; // Interrupt disable
	localparam int B_ICLR    = 4; // Interrupt clear, low active
	localparam int B_DWORD   = 6; // Doubleword mode
	localparam int B_CBY4    = 5; // Count by four
	localparam int B_TEN     = 7; // Timing enable
	localparam int B_BYTE    = 6; // Byte or word mode
	localparam int B_WRAP    = 5; // Address wrap
	localparam int B_CBY2    = 3; // Count by two
	localparam int B_VDBL    = 2; // Vertical doubling
	localparam int B_SELROW  = 1; // Row scan select
	localparam int B_COMPAT  = 0; // Compatibility substitution
	localparam int B_OVF_VDE8 = 1; // Display end bit 8
	localparam int B_OVF_VSS8 = 2; // Sync start bit 8
	localparam int B_OVF_VBS8 = 3; // Blank start bit 8
	localparam int B_OVF_VSS9 = 7; // Sync start bit 9
	localparam int B_CELL_VBS9 = 5; // Blank start bit 9
	localparam int B_LC_SREF = 3; // Single refresh
	localparam int B_EXTA_VBE_HI = 7; // Blank end bit 9
	localparam int B_EXTA_VBE_LO = 6; // Blank end bit 8
	localparam int B_EXTB_PITCH8 = 4; // Pitch bit 8
	localparam int B_EXTB_VBEX = 5; // Blank end extension enable
	localparam int B_STAT_PEND = 7; // Interrupt pending

	// ==========================================================
	// Widths and counts
	localparam int LINE_W = 11; // Scanline counter, up to 2048
	localparam int ADDR_W = 16; // Scan address counter
	localparam logic [2:0] REF_ONE   = 3'h1;
	localparam logic [2:0] REF_THREE = 3'h3;
	localparam logic [2:0] REF_FIVE  = 3'h5;
endpackage : crtcv_pkg

/* File: crtcv_sync_edge.sv */
// Two-stage pin synchroniser with rising edge pulse
`timescale 1ns/10ps
`default_nettype none
module crtcv_sync_edge (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      rise
);
	// ==========================================================
	// Synchroniser chain
	logic meta;  // First stage, read only by the second
	logic sync;  // Second stage
	logic last;  // Previous synchronised level

	// Shift the pin through the chain
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end
		else
		begin
			meta <= pin;
			sync <= meta;
			last <= sync;
		end
	end

	// One-cycle pulse on a rising synchronised level
	assign rise = sync & ~last;
endmodule : crtcv_sync_edge
`default_nettype wire

/* File: crtcv_scan_addr.sv */
// Scan address counter, pitch step and memory address mapping
`timescale 1ns/10ps
`default_nettype none
module crtcv_scan_addr
	import crtcv_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              char_tick,
	input  wire logic              line_tick,
	input  wire logic              row_end,
	input  wire logic              frame_end,
	input  wire logic [ADDR_W-1:0] start_addr,
	input  wire logic [8:0]        pitch,
	input  wire logic              byte_mode,
	input  wire logic              dword_mode,
	input  wire logic              cnt_by2,
	input  wire logic              cnt_by4,
	input  wire logic              wrap16,
	input  wire logic              sel_row,
	input  wire logic              compat,
	input  wire logic [1:0]        row_lsb,
	output logic      [ADDR_W-1:0] mem_addr
);
	// ==========================================================
	// Counters
	logic [ADDR_W-1:0] cnt;        // Scan address counter
	logic [ADDR_W-1:0] row_start;  // Start of current row
	logic [1:0]        div;        // Character clock divider
	logic [ADDR_W-1:0] pitch_sh;   // Shifted pitch
	logic [ADDR_W-1:0] next_start; // Start of next row
	logic              advance;    // Counter step this cycle
	logic              c14;        // Bit 14 after substitution
	logic [ADDR_W-1:0] sub;        // Counter after substitution
	logic [ADDR_W-1:0] next_addr;  // Mapped memory address

	// Pitch is doubled in byte mode, quadrupled in word mode
	assign pitch_sh = byte_mode ? ADDR_W'({pitch, 1'b0})
		: ADDR_W'({pitch, 2'b00});
	assign next_start = row_end ? row_start + pitch_sh : row_start;

	// Divide the character clock by four, two or one
	assign advance = char_tick & (cnt_by4 ? (div == 2'h3)
		: cnt_by2 ? div[0] : 1'b1);

	// Row scan bits replace counter bit 14 when selected
	assign c14 = !compat ? row_lsb[0]
		: !sel_row ? row_lsb[1] : cnt[14];
	assign sub = {cnt[15], c14, cnt[13:0]};

	// Rotate into the memory address
	assign next_addr = dword_mode ? {sub[15:14], sub[11:0], sub[13:12]}
		: byte_mode ? sub
		: wrap16 ? {sub[14:0], sub[15]}
		: {sub[15:14], sub[12:0], sub[13]};

	// Reload at each scanline, step on divided character clock
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt       <= '0;
			row_start <= '0;
			div       <= 2'h0;
			mem_addr  <= '0;
		end
		else
		begin
			mem_addr <= next_addr;
			if (line_tick)
			begin
				row_start <= frame_end ? start_addr : next_start;
				cnt       <= frame_end ? start_addr : next_start;
				div       <= 2'h0;
			end
			else if (char_tick)
			begin
				div <= div + 2'h1;
				if (advance)
					cnt <= cnt + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Checks
	pitch_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
		line_tick && row_end && !frame_end |=>
		cnt == $past(row_start) + $past(pitch_sh))
		else $error("row start not stepped by pitch");
	// Byte mode with both substitutions off passes the counter straight
	byte_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
		byte_mode && !dword_mode && compat && sel_row |=>
		mem_addr == $past(cnt))
		else $error("byte mode address not passed unrotated");
endmodule : crtcv_scan_addr
`default_nettype wire

/* File: crtcv_vtiming.sv */
// Vertical timing, registers and interrupt of the display timing controller
//
// Function
// - Write protect locks indices up to seven
// - Refresh count five, three, or one
// - Disable bit keeps interrupt pin inactive
// - Clear bit low clears pending, forces inactive
// - Sync ends on low four bits match
// - Display ends at nine-bit display end
// - Each row adds pitch to previous start
// - Pitch shifted by one or two
// - Doubleword mode rotates low fourteen counter bits left two
// - Underline drawn on selected cell row, only while text_mode is high
// - Blank starts at ten-bit blank start
// - Blank ends on eight or ten-bit match
// - Timing runs only when enabled
// - Byte mode unrotated, word mode rotated
// - Wrap bit picks sixteen or fourteen bits
// - Count-by-two halves address counter rate
// - Doubling halves scanline counter rate
// - Row scan bit one replaces bit 14
// - Row scan bit zero replaces bit 14
// - Sync starts at sync start field
`timescale 1ns/10ps
`default_nettype none
module crtcv_vtiming
	import crtcv_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic [15:0]       io_addr,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	input  wire logic [7:0]        io_wdata,
	output logic      [7:0]        io_rdata,
	input  wire logic              char_clk,
	input  wire logic              hsync,
	input  wire logic [LINE_W-1:0] vert_total,
	input  wire logic [ADDR_W-1:0] start_addr,
	input  wire logic              text_mode,
	output logic                   vsync,
	output logic                   vblank,
	output logic                   disp_en,
	output logic                   underline,
	output logic      [2:0]        refresh_count,
	output logic                   interrupt_request_pin_n,
	output logic      [ADDR_W-1:0] mem_addr
);
	// ==========================================================
	// Register file
	logic [7:0] index;                 // Data port index
	logic [7:0] vertical_overflow;
	logic [7:0] cell_height_control;
	logic [7:0] vsync_start_low;
	logic [7:0] vsync_end_and_irq_control;
	logic [7:0] vertical_display_end_low;
	logic [7:0] row_pitch;
	logic [7:0] underline_row_and_addr_mode;
	logic [7:0] vertical_blank_start_low;
	logic [7:0] vertical_blank_end_low;
	logic [7:0] timing_mode_control;
	logic [7:0] split_line_compare_low;
	logic [7:0] misc_extension_a;
	logic [7:0] display_extension_b;
	logic       pending;               // Interrupt pending

	// Decode of the I/O strobes
	wire idx_wr  = io_wr && io_addr == IDX_PORT;
	wire data_wr = io_wr && io_addr == DATA_PORT;
	wire locked  = vsync_end_and_irq_control[B_WP]
		&& index <= IX_WP_LAST;
	// Only the line compare extension passes a locked write
	wire [7:0] next_ovf = locked
		? (vertical_overflow & ~OVF_LC_MASK) | (io_wdata & OVF_LC_MASK)
		: io_wdata;
	wire [7:0] rd_reg =
		index == IX_OVF   ? vertical_overflow :
		index == IX_CELL  ? cell_height_control :
		index == IX_VSS   ? vsync_start_low :
		index == IX_VSE   ? vsync_end_and_irq_control :
		index == IX_VDE   ? vertical_display_end_low :
		index == IX_PITCH ? row_pitch :
		index == IX_ULINE ? underline_row_and_addr_mode :
		index == IX_VBS   ? vertical_blank_start_low :
		index == IX_VBE   ? vertical_blank_end_low :
		index == IX_MODE  ? timing_mode_control :
		index == IX_LCMP  ? split_line_compare_low :
		index == IX_EXTA  ? misc_extension_a :
		index == IX_EXTB  ? display_extension_b : 8'h00;
	wire [7:0] stat0 = {pending, 7'h00};
	wire [7:0] next_rdata = !io_rd ? io_rdata :
		io_addr == IDX_PORT   ? index :
		io_addr == DATA_PORT  ? rd_reg :
		io_addr == STAT0_PORT ? stat0 : 8'h00;

	// Register writes through the index and data ports
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			index                       <= REG_RST;
			vertical_overflow           <= REG_RST;
			cell_height_control         <= REG_RST;
			vsync_start_low             <= REG_RST;
			vsync_end_and_irq_control   <= REG_RST;
			vertical_display_end_low    <= REG_RST;
			row_pitch                   <= REG_RST;
			underline_row_and_addr_mode <= REG_RST;
			vertical_blank_start_low    <= REG_RST;
			vertical_blank_end_low      <= REG_RST;
			timing_mode_control         <= REG_RST;
			split_line_compare_low      <= REG_RST;
			misc_extension_a            <= REG_RST;
			display_extension_b         <= REG_RST;
			io_rdata                    <= REG_RST;
		end
		else
		begin
			io_rdata <= next_rdata;
			if (idx_wr)
				index <= io_wdata;
			if (data_wr)
			begin
				unique case (index)
					IX_OVF:   vertical_overflow <= next_ovf;
					IX_CELL:  cell_height_control <= io_wdata;
					IX_VSS:   vsync_start_low <= io_wdata;
					IX_VSE:   vsync_end_and_irq_control <= io_wdata;
					IX_VDE:   vertical_display_end_low <= io_wdata;
					IX_PITCH: row_pitch <= io_wdata;
					IX_ULINE: underline_row_and_addr_mode <= io_wdata;
					IX_VBS:   vertical_blank_start_low <= io_wdata;
					IX_VBE:   vertical_blank_end_low <= io_wdata;
					IX_MODE:  timing_mode_control <= io_wdata;
					IX_LCMP:  split_line_compare_low <= io_wdata;
					IX_EXTA:  misc_extension_a <= io_wdata;
					IX_EXTB:  display_extension_b <= io_wdata;
					default:  ; // Other indices belong elsewhere
				endcase
			end
		end
	end

	// ==========================================================
	// Pin inputs
	logic hs_rise;   // Horizontal sync leading edge
	logic char_tick; // Character clock edge

	crtcv_sync_edge u_hs_sync (
		.mclk (mclk),
		.rst_n(rst_n),
		.pin  (hsync),
		.rise (hs_rise)
	);

	crtcv_sync_edge u_cc_sync (
		.mclk (mclk),
		.rst_n(rst_n),
		.pin  (char_clk),
		.rise (char_tick)
	);

	// ==========================================================
	// Scanline counter
	logic [LINE_W-1:0] line;     // Current scanline
	logic              half;     // Halving phase
	logic [4:0]        row_scan; // Row within character cell

	wire ten       = timing_mode_control[B_TEN];
	wire line_step = hs_rise && ten
		&& (!timing_mode_control[B_VDBL] || half);
	wire line_wrap = line == vert_total;
	wire [LINE_W-1:0] next_line = line_wrap ? '0 : line + 11'h001;
	wire [4:0] cell_h  = cell_height_control[4:0];
	wire row_end       = row_scan == cell_h || line_wrap;
	wire [9:0] vss = {vertical_overflow[B_OVF_VSS9],
		vertical_overflow[B_OVF_VSS8], vsync_start_low};
	wire [9:0] vbs = {cell_height_control[B_CELL_VBS9],
		vertical_overflow[B_OVF_VBS8], vertical_blank_start_low};
	wire [8:0] vde = {vertical_overflow[B_OVF_VDE8],
		vertical_display_end_low};
	wire vbe_ext = display_extension_b[B_EXTB_VBEX];
	wire vs_start = next_line == {1'b0, vss};
	wire vs_end = next_line[3:0] == vsync_end_and_irq_control[3:0];
	wire vb_start = next_line == {1'b0, vbs};
	wire vb_end = vbe_ext
		? next_line[9:0] == {misc_extension_a[B_EXTA_VBE_HI],
			misc_extension_a[B_EXTA_VBE_LO], vertical_blank_end_low}
		: next_line[7:0] == vertical_blank_end_low;
	wire next_disp = ten && line <= {2'b00, vde};

	// Scanline, cell row and halving phase
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !ten)
		begin
			line     <= '0;
			half     <= 1'b0;
			row_scan <= 5'h00;
		end
		else
		begin
			if (hs_rise)
				half <= ~half;
			if (line_step)
			begin
				line     <= next_line;
				row_scan <= row_end ? 5'h00 : row_scan + 5'h01;
			end
		end
	end

	// ==========================================================
	// Sync, blank and display outputs
	wire next_vsync = !ten ? 1'b0 : !line_step ? vsync
		: vs_start ? 1'b1 : vs_end ? 1'b0 : vsync;
	wire next_vblank = !ten ? 1'b0 : !line_step ? vblank
		: vb_start ? 1'b1 : vb_end ? 1'b0 : vblank;
	wire [2:0] next_ref = split_line_compare_low[B_LC_SREF] ? REF_ONE
		: vsync_end_and_irq_control[B_REF5] ? REF_FIVE : REF_THREE;
	wire next_uline = text_mode && ten
		&& row_scan == underline_row_and_addr_mode[4:0];

	// Register the monitor-facing levels
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			vsync         <= 1'b0;
			vblank        <= 1'b0;
			disp_en       <= 1'b0;
			underline     <= 1'b0;
			refresh_count <= REF_THREE;
		end
		else
		begin
			vsync         <= next_vsync;
			vblank        <= next_vblank;
			disp_en       <= next_disp;
			underline     <= next_uline;
			refresh_count <= next_ref;
		end
	end

	// ==========================================================
	// Vertical interrupt
	wire armed = vsync_end_and_irq_control[B_ICLR];
	wire irq_dis = vsync_end_and_irq_control[B_IDIS];
	// Clear level wins over a sync start in the same cycle
	wire next_pend = !armed ? 1'b0
		: pending || (line_step && vs_start && !irq_dis);

	// Pending flag and active-low request pin
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pending                 <= 1'b0;
			interrupt_request_pin_n <= 1'b1;
		end
		else
		begin
			pending                 <= next_pend;
			interrupt_request_pin_n <= !(next_pend && !irq_dis);
		end
	end

	// ==========================================================
	// Scan address path
	crtcv_scan_addr u_scan (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.char_tick (char_tick && ten),
		.line_tick (line_step),
		.row_end   (row_end),
		.frame_end (line_wrap),
		.start_addr(start_addr),
		.pitch     ({display_extension_b[B_EXTB_PITCH8], row_pitch}),
		.byte_mode (timing_mode_control[B_BYTE]),
		.dword_mode(underline_row_and_addr_mode[B_DWORD]),
		.cnt_by2   (timing_mode_control[B_CBY2]),
		.cnt_by4   (underline_row_and_addr_mode[B_CBY4]),
		.wrap16    (timing_mode_control[B_WRAP]),
		.sel_row   (timing_mode_control[B_SELROW]),
		.compat    (timing_mode_control[B_COMPAT]),
		.row_lsb   (row_scan[1:0]),
		.mem_addr  (mem_addr)
	);

	// ==========================================================
	// Checks
	wp_guard_a: assert property (@(posedge mclk) disable iff (!rst_n)
		data_wr && index == IX_OVF && vsync_end_and_irq_control[B_WP] |=>
		vertical_overflow[7:5] == $past(vertical_overflow[7:5])
		&& vertical_overflow[3:0] == $past(vertical_overflow[3:0])
		&& vertical_overflow[4] == $past(io_wdata[4]))
		else $error("protected overflow bits changed");
	refresh_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(split_line_compare_low[B_LC_SREF]) |-> refresh_count == 3'h1)
		else $error("single refresh not selected");
	irq_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(irq_dis) |-> interrupt_request_pin_n)
		else $error("interrupt pin active while disabled");
	irq_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!armed |=> !pending && interrupt_request_pin_n)
		else $error("clear did not drop pending");
	vs_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(vsync) && $past(ten) |->
		line[3:0] == $past(vsync_end_and_irq_control[3:0]))
		else $error("sync ended on wrong line");
	vs_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(vsync) |-> line == {1'b0, $past(vss)})
		else $error("sync started on wrong line");
	vb_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(vblank) |-> line == {1'b0, $past(vbs)})
		else $error("blank started on wrong line");
	disp_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(ten) && $past(line) > {2'b00, $past(vde)} |-> !disp_en)
		else $error("display active past display end");
	ten_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!ten |=> line == '0 && !vsync && !vblank && !disp_en && !underline)
		else $error("timing ran while disabled");
	irq_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(pending) |-> vsync && $past(armed) && !$past(irq_dis))
		else $error("pending set outside sync start");
endmodule : crtcv_vtiming
`default_nettype wire

/* File: crtcv_far_side.sv */
// Far side model: character clock and horizontal sync source
`timescale 1ns/10ps
`default_nettype none
module crtcv_far_side #(
	parameter int LINE_CYC = 60 // Clock cycles per scanline
)(
	input  wire logic mclk,
	input  wire logic run,
	output logic      char_clk,
	output logic      hsync
);
	int cnt; // Position within the scanline
	// ==========================================================
	// Start values
	initial
	begin
		cnt = 0;
		char_clk = 1'b0;
		hsync = 1'b0;
	end
	// ==========================================================
	// Free character clock; a sync pulse each line while running
	always @(posedge mclk)
	begin
		char_clk <= ~char_clk;
		cnt <= (cnt == LINE_CYC - 1) ? 0 : cnt + 1;
		hsync <= run && (cnt < 8);
	end
endmodule : crtcv_far_side
`default_nettype wire

/* File: tb_crtcv_vtiming.sv */
// Self-checking bench for the vertical timing block
`timescale 1ns/10ps
`default_nettype none
module tb_crtcv_vtiming;
	import crtcv_pkg::*;
	// ==========================================================
	// Frame set-up used by the line model
	localparam int VT = 23, VSS = 6, VSE = 9, VDE = 15, VBS = 17, VBE = 21;
	logic        mclk, rst_n, io_wr, io_rd, run, hs_q, tm; // Bench drive
	logic [15:0] io_addr;                               // I/O address
	logic [7:0]  io_wdata, io_rdata, rv, d;             // Bus data
	logic        vsync, vblank, disp_en, irq_n, uline;  // Observed
	logic [2:0]  refresh_count;                         // Observed
	logic [15:0] sa;                                    // Start address
	logic        vs_e, vb_e, irq_e, dis;                // Expected state
	wire         char_clk, hsync;                       // From far side
	int          n_fail, compares, seed, ln, f, i;
	// ==========================================================
	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	crtcv_far_side far (.mclk(mclk), .run(run), .char_clk(char_clk),
		.hsync(hsync));
	crtcv_vtiming dut (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .char_clk(char_clk), .hsync(hsync),
		.vert_total(11'(VT)), .start_addr(sa), .text_mode(tm),
		.vsync(vsync), .vblank(vblank), .disp_en(disp_en), .underline(uline),
		.refresh_count(refresh_count), .interrupt_request_pin_n(irq_n),
		.mem_addr());
	// ==========================================================
	// Compare, verdict and bus tasks
	task automatic check(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic close_out;
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	// One strobed access, held for exactly one taken edge
	task automatic io_cyc(input logic [15:0] a, input logic w,
		input logic [7:0] v);
		@(posedge mclk);
		io_addr <= a;
		io_wr <= w;
		io_rd <= ~w;
		io_wdata <= v;
		@(posedge mclk);
		io_wr <= 1'b0;
		io_rd <= 1'b0;
	endtask : io_cyc
	task automatic wr_reg(input logic [7:0] ix, input logic [7:0] v);
		io_cyc(IDX_PORT, 1'b1, ix);
		io_cyc(DATA_PORT, 1'b1, v);
	endtask : wr_reg
	// Read data lands on the taken edge and is sampled one edge later
	task automatic rd_reg(input logic [7:0] ix, output logic [7:0] v);
		io_cyc(IDX_PORT, 1'b1, ix);
		io_cyc(DATA_PORT, 1'b0, 8'h00);
		@(posedge mclk);
		#1 v = io_rdata;
	endtask : rd_reg
	// Bounded wait for a rising sync, then let the design settle
	task automatic wait_hs;
		int k;
		k = 0;
		hs_q = hsync;
		while (!(hsync === 1'b1 && hs_q === 1'b0) && k < 200)
		begin
			hs_q = hsync;
			@(posedge mclk);
			k++;
		end
		if (k == 200)
		begin
			n_fail++;
			close_out();
		end
		repeat (10) @(posedge mclk);
		#1;
	endtask : wait_hs
	// ==========================================================
	// Main sequence
	initial
	begin
		seed = 51;
		n_fail = 0;
		compares = 0;
		{rst_n, io_wr, io_rd, run, hs_q} = 5'h00;
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		tm = 1'b1;
		sa = 16'($random(seed));
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1 check("irq_n", 8'h01, {7'h00, irq_n});
		// Five, three, then a single refresh
		for (i = 0; i < 3; i++)
		begin
			wr_reg(IX_VSE, (i == 0) ? 8'h40 : 8'h00);
			wr_reg(IX_LCMP, (i == 2) ? 8'h08 : 8'h00);
			repeat (2) @(posedge mclk);
			#1 check("refresh", (i == 0) ? 8'h05 : (i == 1) ? 8'h03 : 8'h01,
				{5'h00, refresh_count});
		end
		// Locked overflow keeps only its always-writable bit
		wr_reg(IX_VSE, 8'h80);
		wr_reg(IX_OVF, 8'hFF);
		rd_reg(IX_OVF, rv);
		check("locked", 8'h10, rv);
		wr_reg(IX_VSE, 8'h00);
		wr_reg(IX_OVF, 8'h2A);
		rd_reg(IX_OVF, rv);
		check("unlocked", 8'h2A, rv);
		// Random readback, doubleword paired with count by four
		for (i = 8'h12; i <= 8'h18; i++)
		begin
			d = 8'($random(seed));
			if (i == 8'h14)
				d = (d & 8'h9F) | {1'b0, d[6], d[6], 5'h00};
			wr_reg(8'(i), d);
			rd_reg(8'(i), rv);
			check("register", d, rv);
		end
		rd_reg(8'h30, rv);
		check("unmapped", 8'h00, rv);
		// Frame set-up, timing enabled just after a sync edge
		wr_reg(IX_MODE, 8'h00);
		wr_reg(IX_OVF, 8'h00);
		wr_reg(IX_VSS, 8'(VSS));
		wr_reg(IX_VSE, 8'h19);
		wr_reg(IX_VDE, 8'(VDE));
		wr_reg(IX_VBS, 8'(VBS));
		wr_reg(IX_VBE, 8'(VBE));
		// Four-line cells, underline on the third line of each
		wr_reg(IX_CELL, 8'h03);
		wr_reg(IX_ULINE, 8'h02);
		run <= 1'b1;
		wait_hs();
		wr_reg(IX_MODE, 8'hC3);
		{ln, f, vs_e, vb_e, irq_e, dis} = {32'd0, 32'd0, 4'h2};
		for (i = 0; i < 3 * (VT + 1); i++)
		begin
			wait_hs();
			ln = (ln == VT) ? 0 : ln + 1;
			f = (ln == 0) ? f + 1 : f;
			if (ln == VSS)
				vs_e = 1'b1;
			else if (ln[3:0] == VSE)
				vs_e = 1'b0;
			if (ln == VBS)
				vb_e = 1'b1;
			else if (ln[7:0] == VBE)
				vb_e = 1'b0;
			if (ln == VSS && !dis)
				irq_e = 1'b0;
			check("vsync", {7'h00, vs_e}, {7'h00, vsync});
			check("vblank", {7'h00, vb_e}, {7'h00, vblank});
			check("disp_en", {7'h00, ln <= VDE}, {7'h00, disp_en});
			check("irq_n", {7'h00, irq_e}, {7'h00, irq_n});
			check("uline", {7'h00, tm && ln % 4 == 2}, {7'h00, uline});
			// Clear then re-arm, disabled in the last frame
			if (ln == 1 && f > 0)
			begin
				wr_reg(IX_VSE, 8'h09);
				@(posedge mclk);
				#1 check("cleared", 8'h01, {7'h00, irq_n});
				dis = (f == 2);
				wr_reg(IX_VSE, dis ? 8'h39 : 8'h19);
				irq_e = 1'b1;
				tm <= (f != 2); // Graphics mode in the last frame
			end
		end
		// Disabled timing drops display in mid-frame
		wait_hs();
		wr_reg(IX_MODE, 8'h43);
		repeat (3) @(posedge mclk);
		#1 check("disabled", 8'h00, {7'h00, disp_en});
		close_out();
	end
endmodule : tb_crtcv_vtiming
`default_nettype wire
